/* File: shared/ssrt_pkg.sv */
// ==========================================================
// Shared constants and carriers of the route translator
`default_nettype none
package ssrt_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [13:0] PORT1_TABLE_IDX = 14'h1220;
	localparam logic [13:0] PORT2_TABLE_IDX = 14'h14A0;
	localparam logic [13:0] PORT3_TABLE_IDX = 14'h1720;
	localparam logic [13:0] PORT4_TABLE_IDX = 14'h19A0;
	localparam logic [13:0] PORT1_BASE_IDX = 14'h1F7F;
	localparam logic [13:0] PORT2_BASE_IDX = 14'h1F9F;
	localparam logic [13:0] PORT3_BASE_IDX = 14'h1FBF;
	localparam logic [13:0] PORT4_BASE_IDX = 14'h1FDF;
	localparam logic [13:0] OFFSET_IDX = 14'h1FF0; // Register offset
	localparam logic [13:0] CTRL_IDX = 14'h1FF1; // Control bits
	localparam logic [13:0] STATUS_IDX = 14'h1FF2; // Read-only state
	// Table geometry
	localparam int ENTRY_REGS = 5;
	localparam int TABLE_ENTRIES = 128;
	localparam int TABLE_REGS = 640;
	localparam logic [15:0] BASE_RESET = 16'h0001;
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0001;
	localparam int CTRL_HONOR_FLAG_BIT = 0;
	localparam int MASTER_FLAG_BIT = 9;
	localparam int MAX_DROPS = 8;
	// Serial opcodes
	localparam logic [7:0] OP_RD_COILS = 8'h01;
	localparam logic [7:0] OP_RD_INPUTS = 8'h02;
	localparam logic [7:0] OP_RD_HOLD = 8'h03;
	localparam logic [7:0] OP_RD_INREG = 8'h04;
	localparam logic [7:0] OP_WR_COIL = 8'h05;
	localparam logic [7:0] OP_WR_REG = 8'h06;
	localparam logic [7:0] OP_WR_COILS = 8'h0F;
	localparam logic [7:0] OP_WR_REGS = 8'h10;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Native message kinds
	typedef enum logic [1:0] {
		KIND_PRIO_READ,
		KIND_PRIO_WRITE,
		KIND_PRINT
	} ssrt_kind_e;
	// Request from the serial master receiver
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] opcode;
		logic [15:0] reg_addr;
		logic [15:0] data;
	} ssrt_req_s;
	// Native message handed to the network side
	typedef struct packed {
		ssrt_kind_e kind;
		logic [3:0] drop_count;
		logic [63:0] drops;
		logic [7:0] addr;
		logic [7:0] opcode;
		logic [15:0] reg_addr;
		logic [15:0] data;
	} ssrt_msg_s;
	// Reply from the network side
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} ssrt_rsp_s;
endpackage : ssrt_pkg
`default_nettype wire

/* File: rtl/ssrt_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Flip-flop FIFO with valid and ready on both sides
module ssrt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg; // Words held
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Flags straight from the count
	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end
	// Pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule : ssrt_fifo
`default_nettype wire

/* File: rtl/ssrt_translator.sv */
// Summary of operation
// - Port table: 128 entries, five registers each
// - Low count byte zero marks entry unassigned
// - Four registers hold eight drops, high first
// - Entry k serves address base plus k
// - Count bit 9 flags master-port target
// - Unassigned entry: request silently ignored
// - Valid route: translate and forward message
// - Non-print reply carries saved request address
// - One request outstanding until reply returns
// - Slave translation uses master-mode settings
// - Opcodes 1-4 become priority reads
// - Opcodes 5, 6, 15, 16 become priority writes
// - Register offset applied in reverse direction
// - Master-flag target: wrap request as print
// - Print reply emitted unchanged to master
// - Tables sit at indexes 4640 to 7199
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssrt_translator #(
	parameter int PORT_NUM = 1, // Which async port, 1 to 4
	parameter int FIFO_DEPTH = 16
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	// AXI4-Lite slave
	input wire logic [15:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [15:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Requests from the serial master
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire ssrt_pkg::ssrt_req_s REQ,
	// Native messages out
	output logic MSG_VALID,
	input wire logic MSG_READY,
	output ssrt_pkg::ssrt_msg_s MSG,
	// Native replies in, serial replies out
	input wire logic NRSP_VALID,
	input wire ssrt_pkg::ssrt_rsp_s NRSP,
	output logic RSP_VALID,
	output ssrt_pkg::ssrt_rsp_s RSP
);
	// ==========================================================
	// Reset synchroniser
	logic rst_meta_reg;
	logic rst_n;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ==========================================================
	// Port selection of table and base indexes
	localparam logic [13:0] TABLE_IDX = (PORT_NUM == 4) ? ssrt_pkg::PORT4_TABLE_IDX :
		(PORT_NUM == 3) ? ssrt_pkg::PORT3_TABLE_IDX :
		(PORT_NUM == 2) ? ssrt_pkg::PORT2_TABLE_IDX : ssrt_pkg::PORT1_TABLE_IDX;
	localparam logic [13:0] BASE_IDX = (PORT_NUM == 4) ? ssrt_pkg::PORT4_BASE_IDX :
		(PORT_NUM == 3) ? ssrt_pkg::PORT3_BASE_IDX :
		(PORT_NUM == 2) ? ssrt_pkg::PORT2_BASE_IDX : ssrt_pkg::PORT1_BASE_IDX;
	localparam logic [13:0] TABLE_END = TABLE_IDX + 14'(ssrt_pkg::TABLE_REGS);

	// ==========================================================
	// Registers
	logic [15:0] table_reg [ssrt_pkg::TABLE_REGS]; // Route table
	logic [15:0] base_reg; // Slave address base
	logic [15:0] offset_reg; // Shared master-mode register offset
	logic [15:0] ctrl_reg; // Bit 0 honours the master flag
	logic [7:0] drop_cnt_reg; // Requests ignored or refused

	// ==========================================================
	// AXI write channel: address and data taken in either order
	logic aw_held_reg;
	logic w_held_reg;
	logic [13:0] aw_idx_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	logic [15:0] wval;
	logic [13:0] tab_w;
	assign do_write = aw_held_reg && w_held_reg && !S_AXI_BVALID;
	assign wval = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
		w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};
	assign tab_w = aw_idx_reg - TABLE_IDX;

	// Channel capture and response
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_idx_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= ssrt_pkg::RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= !aw_held_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
			S_AXI_WREADY <= !w_held_reg && !(S_AXI_WVALID && S_AXI_WREADY);
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg <= S_AXI_AWADDR[15:2];
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (do_write) begin
				// Both halves present: answer and free the channels
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= ((aw_idx_reg >= TABLE_IDX && aw_idx_reg < TABLE_END) ||
					aw_idx_reg == BASE_IDX || aw_idx_reg == ssrt_pkg::OFFSET_IDX ||
					aw_idx_reg == ssrt_pkg::CTRL_IDX) ? ssrt_pkg::RESP_OKAY :
					ssrt_pkg::RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Table storage write, no reset needed
	always_ff @(posedge CLOCK) begin
		if (do_write && aw_idx_reg >= TABLE_IDX && aw_idx_reg < TABLE_END) begin
			table_reg[tab_w[9:0]] <= wval;
		end
	end

	// Configuration registers
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			base_reg <= ssrt_pkg::BASE_RESET;
			offset_reg <= ssrt_pkg::OFFSET_RESET;
			ctrl_reg <= ssrt_pkg::CTRL_RESET;
		end else if (do_write) begin
			if (aw_idx_reg == BASE_IDX) begin
				base_reg <= wval;
			end
			if (aw_idx_reg == ssrt_pkg::OFFSET_IDX) begin
				offset_reg <= wval;
			end
			if (aw_idx_reg == ssrt_pkg::CTRL_IDX) begin
				ctrl_reg <= wval;
			end
		end
	end

	// ==========================================================
	// AXI read channel
	typedef enum {S_IDLE, S_LOOK, S_WAIT} ssrt_state_e;
	ssrt_state_e state_reg;
	logic [13:0] ar_idx;
	logic [13:0] tab_r;
	assign ar_idx = S_AXI_ARADDR[15:2];
	assign tab_r = ar_idx - TABLE_IDX;

	// Read data and response
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= ssrt_pkg::RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= ssrt_pkg::RESP_OKAY;
				if (ar_idx >= TABLE_IDX && ar_idx < TABLE_END) begin
					S_AXI_RDATA <= {16'h0000, table_reg[tab_r[9:0]]};
				end else if (ar_idx == BASE_IDX) begin
					S_AXI_RDATA <= {16'h0000, base_reg};
				end else if (ar_idx == ssrt_pkg::OFFSET_IDX) begin
					S_AXI_RDATA <= {16'h0000, offset_reg};
				end else if (ar_idx == ssrt_pkg::CTRL_IDX) begin
					S_AXI_RDATA <= {16'h0000, ctrl_reg};
				end else if (ar_idx == ssrt_pkg::STATUS_IDX) begin
					// Ignored count, then waiting and busy flags
					S_AXI_RDATA <= {16'h0000, drop_cnt_reg, 6'h00,
						state_reg == S_WAIT, state_reg != S_IDLE};
				end else begin
					S_AXI_RDATA <= '0;
					S_AXI_RRESP <= ssrt_pkg::RESP_SLVERR;
				end
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Route lookup of the held request
	ssrt_pkg::ssrt_req_s req_reg; // Held request, address kept for reply
	logic print_reg; // Outstanding request went as a print
	logic [7:0] k; // Entry number
	logic in_range;
	logic [9:0] ent;
	logic [15:0] cnt_word;
	logic assigned;
	logic as_print;
	logic is_rd;
	logic is_wr;
	logic route_ok;
	logic fwd;
	logic f_ready;
	ssrt_pkg::ssrt_msg_s msg;
	assign k = req_reg.addr - base_reg[7:0];
	assign in_range = (base_reg[15:8] == 8'h00) && (req_reg.addr >= base_reg[7:0]) &&
		(k < 8'(ssrt_pkg::TABLE_ENTRIES));
	assign ent = 10'(k) * 10'(ssrt_pkg::ENTRY_REGS);
	assign cnt_word = table_reg[ent];
	assign assigned = in_range && (cnt_word[7:0] != 8'h00);
	assign as_print = cnt_word[ssrt_pkg::MASTER_FLAG_BIT] &&
		ctrl_reg[ssrt_pkg::CTRL_HONOR_FLAG_BIT];
	assign is_rd = (req_reg.opcode == ssrt_pkg::OP_RD_COILS) ||
		(req_reg.opcode == ssrt_pkg::OP_RD_INPUTS) ||
		(req_reg.opcode == ssrt_pkg::OP_RD_HOLD) ||
		(req_reg.opcode == ssrt_pkg::OP_RD_INREG);
	assign is_wr = (req_reg.opcode == ssrt_pkg::OP_WR_COIL) ||
		(req_reg.opcode == ssrt_pkg::OP_WR_REG) ||
		(req_reg.opcode == ssrt_pkg::OP_WR_COILS) ||
		(req_reg.opcode == ssrt_pkg::OP_WR_REGS);
	assign route_ok = assigned && (as_print || is_rd || is_wr);
	assign fwd = (state_reg == S_LOOK) && route_ok;

	// Build the native message
	always_comb begin
		msg = '0;
		msg.drop_count = (cnt_word[7:0] > 8'(ssrt_pkg::MAX_DROPS)) ?
			4'(ssrt_pkg::MAX_DROPS) : cnt_word[3:0];
		// Drop 1 in the high byte of the second register
		msg.drops = {table_reg[ent + 10'h001], table_reg[ent + 10'h002],
			table_reg[ent + 10'h003], table_reg[ent + 10'h004]};
		msg.addr = req_reg.addr;
		msg.opcode = req_reg.opcode;
		msg.data = req_reg.data;
		if (as_print) begin
			// Request wrapped unchanged
			msg.kind = ssrt_pkg::KIND_PRINT;
			msg.reg_addr = req_reg.reg_addr;
		end else begin
			// Master mode subtracts the offset, so add it here
			msg.kind = is_rd ? ssrt_pkg::KIND_PRIO_READ : ssrt_pkg::KIND_PRIO_WRITE;
			msg.reg_addr = 16'(req_reg.reg_addr + offset_reg);
		end
	end

	// ==========================================================
	// Request sequencer, one request in flight
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			REQ_READY <= 1'b0;
			req_reg <= '0;
			print_reg <= 1'b0;
			drop_cnt_reg <= '0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					REQ_READY <= 1'b1;
					if (REQ_VALID && REQ_READY) begin
						req_reg <= REQ;
						REQ_READY <= 1'b0;
						state_reg <= S_LOOK;
					end
				end
				S_LOOK: begin
					if (!route_ok) begin
						// Quietly dropped, ready for the next
						drop_cnt_reg <= drop_cnt_reg + 8'h01;
						REQ_READY <= 1'b1;
						state_reg <= S_IDLE;
					end else if (f_ready) begin
						print_reg <= as_print;
						state_reg <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (NRSP_VALID) begin
						REQ_READY <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// Reply to the master
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			RSP_VALID <= 1'b0;
			RSP <= '0;
		end else begin
			RSP_VALID <= (state_reg == S_WAIT) && NRSP_VALID;
			if ((state_reg == S_WAIT) && NRSP_VALID) begin
				RSP.data <= NRSP.data;
				RSP.addr <= print_reg ? NRSP.addr : req_reg.addr;
			end
		end
	end

	// ==========================================================
	// Message FIFO
	ssrt_fifo #(
		.WIDTH($bits(ssrt_pkg::ssrt_msg_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLOCK),
		.rst_n(rst_n),
		.in_valid(fwd),
		.in_ready(f_ready),
		.in_data(msg),
		.out_valid(MSG_VALID),
		.out_ready(MSG_READY),
		.out_data(MSG)
	);

	// ==========================================================
	// Checks
	a_busy_no_accept: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state_reg != S_IDLE) |-> !REQ_READY) else $error("request accepted while busy");
	a_unassigned_dropped: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state_reg == S_LOOK && !assigned) |-> !fwd ##1 state_reg == S_IDLE)
		else $error("unassigned entry forwarded");
	a_read_kind: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(fwd && is_rd && !as_print) |-> msg.kind == ssrt_pkg::KIND_PRIO_READ)
		else $error("read opcode not priority read");
	a_write_kind: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(fwd && is_wr && !as_print) |-> msg.kind == ssrt_pkg::KIND_PRIO_WRITE)
		else $error("write opcode not priority write");
	a_offset_reverse: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(fwd && !as_print) |-> msg.reg_addr == 16'(req_reg.reg_addr + offset_reg))
		else $error("offset not added");
	a_print_wrap: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(fwd && as_print) |-> msg.kind == ssrt_pkg::KIND_PRINT &&
		msg.reg_addr == req_reg.reg_addr) else $error("print not unchanged");
	a_bad_opcode: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state_reg == S_LOOK && !as_print && !is_rd && !is_wr) |-> !fwd)
		else $error("unsupported opcode forwarded");
	a_reply_addr: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state_reg == S_WAIT && NRSP_VALID && !print_reg) |=> RSP_VALID &&
		RSP.addr == $past(req_reg.addr)) else $error("reply address wrong");
	a_print_reply: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state_reg == S_WAIT && NRSP_VALID && print_reg) |=> RSP_VALID &&
		RSP == $past(NRSP)) else $error("print reply altered");
	a_bresp_hold: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
endmodule : ssrt_translator
`default_nettype wire

/* File: verif/ssrt_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial master model: one request at a time, held until taken
module ssrt_master_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire ssrt_pkg::ssrt_req_s start_req,
	input wire logic req_ready,
	output logic req_valid,
	output ssrt_pkg::ssrt_req_s req,
	output logic busy
);
	logic wait_reg; // Taken, awaiting reply or drop
	// Issue, hold until taken, then wait before the next request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_valid <= 1'b0;
			req <= '0;
			busy <= 1'b0;
			wait_reg <= 1'b0;
		end else if (start && !busy) begin // New request only when idle
			req_valid <= 1'b1;
			req <= start_req;
			busy <= 1'b1;
		end else if (req_valid && req_ready) begin // Released lines flip, never stale
			req_valid <= 1'b0;
			req <= ~req;
			wait_reg <= 1'b1;
		end else if (wait_reg && req_ready) begin // Reply or drop frees the port
			wait_reg <= 1'b0;
			busy <= 1'b0;
		end
	end
endmodule : ssrt_master_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========================================================
	// Signals and scoreboard
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, req_valid, req_ready, msg_valid, rsp_valid;
	logic busy;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF; // Write strobes
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic msg_ready = 0, nrsp_valid = 0, start = 0, seeded = 0;
	ssrt_pkg::ssrt_req_s req, start_req = '0;
	ssrt_pkg::ssrt_msg_s msg;
	ssrt_pkg::ssrt_rsp_s nrsp = '0, rsp;
	logic [127:0] b_q[$], r_q[$], m_q[$], p_q[$]; // Expected results, oldest first
	int miscompares = 0, tests_run = 0, ign = 0, msg_cnt = 0;
	logic [15:0] base = 16'h0001, offset = 16'h0000, ctrl = 16'h0001; // Mirror of settings
	logic [15:0] cnt [128]; // Mirror of count registers
	logic [63:0] drp [128]; // Mirror of drop registers
	logic [7:0] ops [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10};
	localparam logic [1:0] OK = ssrt_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = ssrt_pkg::RESP_SLVERR;
	// Clock
	always #5 clk = ~clk;
	// Network side stalls at random
	always @(posedge clk) msg_ready <= seeded ? ($urandom_range(3) != 0) : 1'b0;
	// ==========================================================
	// Design and partner
	ssrt_translator #(.PORT_NUM(1), .FIFO_DEPTH(16)) uut (.CLOCK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req), .MSG_VALID(msg_valid),
		.MSG_READY(msg_ready), .MSG(msg), .NRSP_VALID(nrsp_valid), .NRSP(nrsp),
		.RSP_VALID(rsp_valid), .RSP(rsp));
	ssrt_master_model master (.clk(clk), .rst_n(rst_n), .start(start), .start_req(start_req),
		.req_ready(req_ready), .req_valid(req_valid), .req(req), .busy(busy));
	// ==========================================================
	// Checking
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// Expired wait counts as a mismatch
	task automatic tmo();
		miscompares++;
		$display("[FAIL] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
		end_sim();
	endtask : tmo
	// Watcher: each result taken against the oldest note
	always @(posedge clk) begin
		if (bvalid && bready) chk({126'h0, bresp}, b_q.pop_front());
		if (rvalid && rready) chk({94'h0, rresp, rdata}, r_q.pop_front());
		if (msg_valid && msg_ready) begin
			msg_cnt++;
			chk({10'h0, msg}, m_q.size() ? m_q.pop_front() : 'x);
		end
		if (rsp_valid) chk({104'h0, rsp}, p_q.size() ? p_q.pop_front() : 'x);
	end
	// ==========================================================
	// Register bus tasks
	function automatic logic [15:0] ta(input int k, input int j);
		return {14'(int'(ssrt_pkg::PORT1_TABLE_IDX) + 5 * k + j), 2'b00};
	endfunction : ta
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] e);
		int n;
		logic pend;
		b_q.push_back({126'h0, e});
		awaddr <= a;
		wdata <= {16'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pend = 1'b1;
		// Each channel held until its own edge; a local flag ends the wait
		for (n = 0; n < 100 && pend; n++) begin
			@(posedge clk);
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				pend = 1'b0;
			end
		end
		if (pend) tmo();
		@(posedge clk); // One edge between transfers
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic [1:0] e);
		int n;
		logic pend;
		r_q.push_back({94'h0, e, 16'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		pend = 1'b1;
		for (n = 0; n < 100 && pend; n++) begin
			@(posedge clk);
			if (arready && arvalid) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				pend = 1'b0;
			end
		end
		if (pend) tmo();
		@(posedge clk); // One edge between transfers
	endtask : rd
	// Fill one table entry with a count and random drops
	task automatic prog(input int k, input logic [15:0] c);
		int j;
		cnt[k] = c;
		drp[k] = {$urandom, $urandom};
		wr(ta(k, 0), c, OK);
		for (j = 1; j < 5; j++) wr(ta(k, j), drp[k][79 - 16 * j -: 16], OK);
	endtask : prog
	// ==========================================================
	// One serial request with its expected message and reply
	task automatic xfer(input logic [7:0] a, input logic [7:0] op);
		ssrt_pkg::ssrt_req_s q;
		ssrt_pkg::ssrt_msg_s e;
		ssrt_pkg::ssrt_rsp_s r;
		int k, n, m;
		logic ok, pr;
		k = int'(8'(a - base[7:0]));
		q = '{addr: a, opcode: op, reg_addr: 16'($urandom), data: 16'($urandom)};
		pr = 1'b0;
		ok = (base < 16'h0100) && (k < 128) && (a >= base[7:0]);
		if (ok) begin // Flag honoured only while enabled
			pr = ctrl[0] && cnt[k][9];
			ok = cnt[k][7:0] != 8'h00 && (pr || (op >= 8'h01 && op <= 8'h06) || op >= 8'h0F && op <= 8'h10);
		end
		if (ok) begin // Forwarded: build the native message
			e.kind = pr ? ssrt_pkg::KIND_PRINT : (op <= 8'h04 ? ssrt_pkg::KIND_PRIO_READ : ssrt_pkg::KIND_PRIO_WRITE);
			e.drop_count = cnt[k][7:0] > 8'h08 ? 4'h8 : cnt[k][3:0];
			e.drops = drp[k];
			e.addr = a;
			e.opcode = op;
			e.reg_addr = pr ? q.reg_addr : q.reg_addr + offset;
			e.data = q.data;
			m_q.push_back({10'h0, e});
		end else ign++;
		for (n = 0; n < 100 && busy; n++) @(posedge clk);
		if (busy) tmo();
		start_req <= q;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		m = msg_cnt;
		if (ok) begin // Reply comes back once the message has left
			for (n = 0; n < 100 && msg_cnt == m; n++) @(posedge clk);
			if (msg_cnt == m) tmo();
			r = {8'($urandom), 16'($urandom)};
			p_q.push_back({104'h0, pr ? r.addr : a, r.data});
			nrsp_valid <= 1'b1;
			nrsp <= r;
			@(posedge clk);
			nrsp_valid <= 1'b0;
			nrsp <= ~r;
		end
		for (n = 0; n < 100 && busy; n++) @(posedge clk);
		if (busy) tmo();
		repeat (3) @(posedge clk);
	endtask : xfer
	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		void'($urandom(32'hD41A));
		seeded = 1'b1;
		rd({ssrt_pkg::PORT1_BASE_IDX, 2'b00}, 16'h0001, OK);
		rd({ssrt_pkg::OFFSET_IDX, 2'b00}, 16'h0000, OK);
		rd({ssrt_pkg::CTRL_IDX, 2'b00}, 16'h0001, OK);
		wstrb <= 4'h1;
		wr({ssrt_pkg::OFFSET_IDX, 2'b00}, 16'hABCD, OK);
		wstrb <= 4'hF;
		rd({ssrt_pkg::OFFSET_IDX, 2'b00}, 16'h00CD, OK);
		rd(16'h0010, 16'h0000, ERR);
		wr(16'h0010, 16'hFFFF, ERR);
		$display("test 1 done");
		prog(0, 16'h0003);
		prog(2, 16'h0201);
		prog(5, 16'h0200);
		prog(127, 16'h000C);
		rd(ta(127, 4), drp[127][15:0], OK);
		$display("test 2 done");
		wr({ssrt_pkg::OFFSET_IDX, 2'b00}, 16'h0010, OK);
		offset = 16'h0010;
		foreach (ops[i]) xfer(8'h01, ops[i]);
		xfer(8'h80, ssrt_pkg::OP_RD_HOLD);
		$display("test 3 done");
		xfer(8'h06, ssrt_pkg::OP_RD_HOLD);
		xfer(8'h00, ssrt_pkg::OP_RD_HOLD);
		xfer(8'hC8, ssrt_pkg::OP_RD_HOLD);
		xfer(8'h01, 8'h07);
		rd({ssrt_pkg::STATUS_IDX, 2'b00}, {8'(ign), 8'h00}, OK);
		$display("test 4 done");
		xfer(8'h03, ssrt_pkg::OP_RD_HOLD);
		xfer(8'h03, 8'h41);
		wr({ssrt_pkg::CTRL_IDX, 2'b00}, 16'h0000, OK);
		ctrl = 16'h0000;
		xfer(8'h03, ssrt_pkg::OP_WR_REG);
		$display("test 5 done");
		wr({ssrt_pkg::PORT1_BASE_IDX, 2'b00}, 16'h0080, OK);
		base = 16'h0080;
		xfer(8'h80, ssrt_pkg::OP_RD_COILS);
		xfer(8'hFF, ssrt_pkg::OP_WR_REGS);
		xfer(8'h7F, ssrt_pkg::OP_RD_HOLD);
		rd({ssrt_pkg::PORT1_BASE_IDX, 2'b00}, 16'h0080, OK);
		$display("test 6 done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
